// ### tb/msm_sensor_model.sv
`timescale 1ns/1ps
// Sensor-side stand-in: tacho edges, encoder clock, timebase tick, hall levels
module msm_sensor_model (
  input wire logic aclk,
  output logic tacho_capture,
  output logic encoder_tick,
  output logic rtc_tick,
  output logic [2:0] sensor_input_pins
);
  // Lines quiet at start; hall levels start low
  initial begin
    tacho_capture = 1'b0;
    encoder_tick = 1'b0;
    rtc_tick = 1'b0;
    sensor_input_pins = 3'h0;
  end

  task automatic tacho_pulse();
    @(posedge aclk);
    tacho_capture <= 1'b1;
    @(posedge aclk);
    tacho_capture <= 1'b0;
  endtask : tacho_pulse

  // encoder pulses, gapped so none merge
  task automatic enc_pulses(input int n);
    repeat (n) begin
      @(posedge aclk);
      encoder_tick <= 1'b1;
      @(posedge aclk);
      encoder_tick <= 1'b0;
    end
  endtask : enc_pulses

  // timebase tick for automatic encoder capture
  task automatic rtc_pulse();
    @(posedge aclk);
    rtc_tick <= 1'b1;
    @(posedge aclk);
    rtc_tick <= 1'b0;
  endtask : rtc_pulse

  task automatic hall_toggle(input int idx);
    @(posedge aclk);
    sensor_input_pins[idx] <= ~sensor_input_pins[idx];
  endtask : hall_toggle
endmodule : msm_sensor_model

// ### tb/tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) chk(n, 32'(e), 32'(g))
module tb;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, tacho, enc, rtc;
  logic capf, serr, plusf, minusf, hallf, ce;
  logic [5:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d, v;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic [2:0] pins;
  int bad_count, comparisons;

  // Free-running 40 MHz clock
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  msm_timer msm_timer_i (.aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .tacho_capture(tacho), .encoder_tick(enc), .rtc_tick(rtc), .sensor_input_pins(pins),
    .capture_flag(capf), .speed_error_flag(serr), .prescaler_plus_flag(plusf),
    .prescaler_minus_flag(minusf), .hall_event_flag(hallf));

  msm_sensor_model msm_sensor_model_i (.aclk(aclk), .tacho_capture(tacho), .encoder_tick(enc),
    .rtc_tick(rtc), .sensor_input_pins(pins));

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %0h seen %0h", n, e, g);
    end
  endtask : chk

  // Bounded wait ran dry: count it and close the run
  task automatic hung(input int n);
    if (n >= 64) begin
      bad_count++;
      give_verdict();
    end
  endtask : hung

  // Bus write: address and data offered together, each dropped when taken
  task automatic wr(input logic [5:0] a, input logic [31:0] dat, output logic [1:0] rsp);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= dat;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    hung(n);
    rsp = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [5:0] a, output logic [31:0] dat, output logic [1:0] rsp);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    hung(n);
    dat = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask : rd

  task automatic wreg(input logic [5:0] a, input logic [7:0] dat);
    wr(a, {24'h000000, dat}, r);
  endtask : wreg

  task automatic rchk(input string n, input logic [5:0] a, input logic [7:0] e);
    rd(a, d, r);
    `CHK(n, {24'h000000, e}, d);
  endtask : rchk

  // Flags sampled mid-cycle, well clear of the launching edge
  task automatic fchk(input string n, input int b, input logic e);
    logic [4:0] f;
    @(negedge aclk);
    f = {hallf, serr, capf, plusf, minusf};
    `CHK(n, e, f[b]);
  endtask : fchk

  // Back to configuration, preload timer and prescaler, clear flags
  task automatic cfg(input logic [7:0] ps, input logic [7:0] hi, input logic [7:0] lo);
    wreg(msm_pkg::OFF_CTRL, 8'h00);
    wreg(msm_pkg::OFF_TIMH, hi);
    wreg(msm_pkg::OFF_TIML, lo);
    wreg(msm_pkg::OFF_PRSC, ps);
    wreg(msm_pkg::OFF_STAT, 8'h1F);
  endtask : cfg

  // Main sequence
  initial begin
    logic [5:0] ra [7];
    logic [7:0] rv [7];
    ra = '{msm_pkg::OFF_TIMH, msm_pkg::OFF_TIML, msm_pkg::OFF_PRSC, msm_pkg::OFF_COMM,
      msm_pkg::OFF_DEMAG, msm_pkg::OFF_ZCAP, msm_pkg::OFF_ZPRV};
    rv = '{8'h12, 8'h34, 8'h03, 8'h56, 8'h78, 8'h9A, 8'hBC};
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    ce = 1'b1;
    {awaddr, araddr, wdata, wstrb} = {6'h00, 6'h00, 32'h00000000, 4'hF};
    bad_count = 0;
    comparisons = 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rchk("ctrl reset", msm_pkg::OFF_CTRL, 8'h00);
    rchk("stat reset", msm_pkg::OFF_STAT, 8'h00);
    for (int i = 0; i < 7; i++) wreg(ra[i], rv[i]);
    for (int i = 0; i < 7; i++) rchk("config rw", ra[i], rv[i]);
    wr(6'h28, 32'h000000FF, r);
    `CHK("unmapped bresp", msm_pkg::RESP_SLVERR, r);
    rd(6'h28, d, r);
    `CHK("unmapped rresp", msm_pkg::RESP_SLVERR, r);
    // Tacho period at prescaler 1, then step down and read-only timer and prescaler
    cfg(8'h01, 8'h00, 8'h00);
    wreg(msm_pkg::OFF_CTRL, 8'h0A);
    repeat (100) @(posedge aclk);
    msm_sensor_model_i.tacho_pulse();
    rd(msm_pkg::OFF_ZCAP, v, r);
    rd(msm_pkg::OFF_ZPRV, d, r);
    `CHK("tacho period", 1'b1, ({v[7:0], d[7:0]} >= 16'd48 && {v[7:0], d[7:0]} <= 16'd60));
    fchk("capture flag", msm_pkg::ST_CAPT, 1'b1);
    fchk("minus flag", msm_pkg::ST_MINUS, 1'b1);
    rchk("prescaler down", msm_pkg::OFF_PRSC, 8'h00);
    wreg(msm_pkg::OFF_TIMH, 8'hAA);
    wreg(msm_pkg::OFF_PRSC, 8'h05);
    rchk("timh read only", msm_pkg::OFF_TIMH, 8'h00);
    rchk("prsc read only", msm_pkg::OFF_PRSC, 8'h00);
    // Long period captured, then a short one that the lock must drop
    repeat (150) @(posedge aclk);
    msm_sensor_model_i.tacho_pulse();
    rd(msm_pkg::OFF_ZCAP, v, r);
    msm_sensor_model_i.tacho_pulse();
    rd(msm_pkg::OFF_ZPRV, d, r);
    `CHK("locked low", 1'b1, ({v[7:0], d[7:0]} >= 16'd160 && {v[7:0], d[7:0]} <= 16'd190));
    // Speed error threshold 01FFh with compare byte 01h
    wreg(msm_pkg::OFF_DEMAG, 8'h01);
    msm_sensor_model_i.tacho_pulse();
    repeat (300) @(posedge aclk);
    fchk("no speed error", msm_pkg::ST_SPDERR, 1'b0);
    // Clock enable low must freeze the counter
    @(posedge aclk);
    ce <= 1'b0;
    repeat (400) @(posedge aclk);
    ce <= 1'b1;
    fchk("frozen no error", msm_pkg::ST_SPDERR, 1'b0);
    repeat (300) @(posedge aclk);
    fchk("speed error", msm_pkg::ST_SPDERR, 1'b1);
    // Overflow at FFFFh steps the prescaler up
    cfg(8'h02, 8'hFF, 8'hF0);
    wreg(msm_pkg::OFF_CTRL, 8'h0A);
    repeat (100) @(posedge aclk);
    rchk("prescaler up", msm_pkg::OFF_PRSC, 8'h03);
    fchk("plus flag", msm_pkg::ST_PLUS, 1'b1);
    // Prescaler 15: counter parks at FFFFh, capture still works
    cfg(8'h0F, 8'hFF, 8'hFF);
    wreg(msm_pkg::OFF_CTRL, 8'h0A);
    repeat (33000) @(posedge aclk); // One full divide so a tick lands at FFFFh
    rchk("park high", msm_pkg::OFF_TIMH, 8'hFF);
    rchk("park ps", msm_pkg::OFF_PRSC, 8'h0F);
    fchk("park no plus", msm_pkg::ST_PLUS, 1'b0);
    msm_sensor_model_i.tacho_pulse();
    rchk("park cap high", msm_pkg::OFF_ZCAP, 8'hFF);
    rchk("park cap low", msm_pkg::OFF_ZPRV, 8'hFF);
    // Autoswitched then switched prescaler handling
    cfg(8'h00, 8'hF0, 8'h00);
    wreg(msm_pkg::OFF_CTRL, 8'h06);
    repeat (40) @(posedge aclk);
    rchk("auto up", msm_pkg::OFF_PRSC, 8'h01);
    fchk("auto plus", msm_pkg::ST_PLUS, 1'b1);
    wreg(msm_pkg::OFF_STAT, 8'h02);
    fchk("auto clear", msm_pkg::ST_PLUS, 1'b0);
    wreg(msm_pkg::OFF_CTRL, 8'h02);
    wreg(msm_pkg::OFF_STAT, 8'h02);
    rchk("sw plus", msm_pkg::OFF_PRSC, 8'h02);
    wreg(msm_pkg::OFF_STAT, 8'h01);
    wreg(msm_pkg::OFF_STAT, 8'h00);
    wreg(msm_pkg::OFF_PRSC, 8'h09);
    rchk("sw minus", msm_pkg::OFF_PRSC, 8'h01);
    // Encoder counts up despite direction bit; read and tick captures
    cfg(8'h00, 8'h00, 8'h00);
    wreg(msm_pkg::OFF_CTRL, 8'h7A);
    msm_sensor_model_i.enc_pulses(20);
    rchk("enc read cap", msm_pkg::OFF_TIMH, 8'h00);
    rchk("enc cap high", msm_pkg::OFF_ZCAP, 8'h00);
    rchk("enc cap low", msm_pkg::OFF_ZPRV, 8'h14);
    wreg(msm_pkg::OFF_CTRL, 8'h3A);
    msm_sensor_model_i.enc_pulses(7);
    msm_sensor_model_i.rtc_pulse();
    rchk("rtc cap high", msm_pkg::OFF_ZCAP, 8'h00);
    rchk("rtc cap low", msm_pkg::OFF_ZPRV, 8'h07);
    // Hall: which sensor toggled
    wreg(msm_pkg::OFF_CTRL, 8'h12);
    msm_sensor_model_i.hall_toggle(1);
    repeat (3) @(posedge aclk);
    rchk("hall mask", msm_pkg::OFF_HALL, 8'h12);
    fchk("hall flag", msm_pkg::ST_HALL, 1'b1);
    give_verdict();
  end
endmodule : tb

// ### verilog/msm_pkg.sv
package msm_pkg;
  // Register byte offsets on the AXI4-Lite bus
  localparam logic [5:0] OFF_CTRL = 6'h00;
  localparam logic [5:0] OFF_PRSC = 6'h04;
  localparam logic [5:0] OFF_TIMH = 6'h08;
  localparam logic [5:0] OFF_TIML = 6'h0C;
  localparam logic [5:0] OFF_ZCAP = 6'h10;
  localparam logic [5:0] OFF_ZPRV = 6'h14;
  localparam logic [5:0] OFF_COMM = 6'h18;
  localparam logic [5:0] OFF_DEMAG = 6'h1C;
  localparam logic [5:0] OFF_STAT = 6'h20;
  localparam logic [5:0] OFF_HALL = 6'h24;
  localparam logic [5:0] OFF_LAST = OFF_HALL;

  // Control register fields
  localparam int unsigned CTRL_W = 7;
  localparam int unsigned CTRL_RST = 0;
  localparam int unsigned CTRL_CKE = 1;
  localparam int unsigned CTRL_SWA = 2;
  localparam int unsigned CTRL_TES_LO = 3;
  localparam int unsigned CTRL_TES_HI = 4;
  localparam int unsigned CTRL_COUNT_DIRECTION_BIT = 5;
  localparam int unsigned CTRL_ECM = 6;

  // Status register fields
  localparam int unsigned STAT_W = 5;
  localparam int unsigned ST_MINUS = 0;
  localparam int unsigned ST_PLUS = 1;
  localparam int unsigned ST_CAPT = 2;
  localparam int unsigned ST_SPDERR = 3;
  localparam int unsigned ST_HALL = 4;

  // Speed sensor selection codes
  localparam logic [1:0] TES_SWITCH = 2'h0;
  localparam logic [1:0] TES_TACHO = 2'h1;
  localparam logic [1:0] TES_HALL = 2'h2;
  localparam logic [1:0] TES_ENC = 2'h3;

  // Counter and prescaler limits
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] CNT_LOW_LIMIT = 16'h5500;
  localparam logic [7:0] CMP_LOW_BYTE = 8'hFF;
  localparam logic [7:0] TIMH_MAX = 8'hFF;
  localparam logic [7:0] TIMH_MIN = 8'h00;
  localparam logic [3:0] PS_MAX = 4'hF;
  localparam logic [3:0] PS_MIN = 4'h0;
  localparam logic [15:0] DIV_ONE = 16'h0001;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum {MODE_HOLD, MODE_CFG, MODE_SW, MODE_AUTO, MODE_SPEED} msm_mode_t;

  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;
    logic [3:0] ps;
    logic [15:0] cnt;
    logic [15:0] cap;
    logic [7:0] comm;
    logic [7:0] demag;
    logic [STAT_W-1:0] stat;
    logic [2:0] hall_prev;
    logic [2:0] hall_tog;
    logic lock;
    logic [14:0] div;
  } msm_regs_t;

  typedef struct packed {
    logic aw_got;
    logic [5:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } msm_axi_t;

  localparam msm_regs_t REGS_RESET = '0;
  localparam msm_axi_t AXI_RESET = '0;
endpackage : msm_pkg

// ### verilog/msm_timer.sv
`timescale 1ns/1ps
module msm_timer (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic tacho_capture,
  input wire logic encoder_tick,
  input wire logic rtc_tick,
  input wire logic [2:0] sensor_input_pins,
  output logic capture_flag,
  output logic speed_error_flag,
  output logic prescaler_plus_flag,
  output logic prescaler_minus_flag,
  output logic hall_event_flag
);
  msm_pkg::msm_regs_t r_reg, r_next;
  msm_pkg::msm_axi_t a_reg, a_next;
  msm_pkg::msm_mode_t mode;
  logic running, encoder, src_evt, tick, cap_evt, hall_toggled;
  logic wr_en, wr_act, rd_en, rd_ok;
  logic [15:0] lim;
  logic [31:0] rd_val;

  // Handshake readies straight from state; a frozen block accepts nothing
  assign s_axi_awready = ce & ~a_reg.aw_got;
  assign s_axi_wready = ce & ~a_reg.w_got;
  assign s_axi_arready = ce & ~a_reg.rvalid;
  assign s_axi_bvalid = a_reg.bvalid;
  assign s_axi_bresp = a_reg.bresp;
  assign s_axi_rvalid = a_reg.rvalid;
  assign s_axi_rdata = a_reg.rdata;
  assign s_axi_rresp = a_reg.rresp;
  assign capture_flag = r_reg.stat[msm_pkg::ST_CAPT];
  assign speed_error_flag = r_reg.stat[msm_pkg::ST_SPDERR];
  assign prescaler_plus_flag = r_reg.stat[msm_pkg::ST_PLUS];
  assign prescaler_minus_flag = r_reg.stat[msm_pkg::ST_MINUS];
  assign hall_event_flag = r_reg.stat[msm_pkg::ST_HALL];

  // Mode decode, counter clock and event sources
  always_comb begin
    if (r_reg.ctrl[msm_pkg::CTRL_RST]) begin
      mode = msm_pkg::MODE_HOLD;
    end else if (!r_reg.ctrl[msm_pkg::CTRL_CKE]) begin
      mode = msm_pkg::MODE_CFG;
    end else if (r_reg.ctrl[msm_pkg::CTRL_TES_HI:msm_pkg::CTRL_TES_LO] != msm_pkg::TES_SWITCH) begin
      mode = msm_pkg::MODE_SPEED;
    end else if (r_reg.ctrl[msm_pkg::CTRL_SWA]) begin
      mode = msm_pkg::MODE_AUTO;
    end else begin
      mode = msm_pkg::MODE_SW;
    end
    running = (mode == msm_pkg::MODE_SW) || (mode == msm_pkg::MODE_AUTO) || (mode == msm_pkg::MODE_SPEED);
    encoder = r_reg.ctrl[msm_pkg::CTRL_TES_HI:msm_pkg::CTRL_TES_LO] == msm_pkg::TES_ENC;
    src_evt = (mode == msm_pkg::MODE_SPEED && encoder) ? encoder_tick : 1'b1;
    lim = (msm_pkg::DIV_ONE << r_reg.ps) - msm_pkg::DIV_ONE;
    tick = running & src_evt & (r_reg.div >= lim[14:0]); // No long stall after a prescaler step down
    hall_toggled = |(sensor_input_pins ^ r_reg.hall_prev);
    wr_en = a_reg.aw_got & a_reg.w_got & ~a_reg.bvalid;
    wr_act = wr_en & a_reg.wstrb0 & (a_reg.awaddr[1:0] == 2'h0) & (a_reg.awaddr <= msm_pkg::OFF_LAST);
    rd_en = s_axi_arvalid & s_axi_arready;
    rd_ok = (s_axi_araddr[1:0] == 2'h0) && (s_axi_araddr <= msm_pkg::OFF_LAST);
    cap_evt = 1'b0;
    if (mode == msm_pkg::MODE_SPEED) begin
      case (r_reg.ctrl[msm_pkg::CTRL_TES_HI:msm_pkg::CTRL_TES_LO])
        msm_pkg::TES_TACHO: cap_evt = tacho_capture;
        msm_pkg::TES_HALL: cap_evt = hall_toggled;
        msm_pkg::TES_ENC: cap_evt = r_reg.ctrl[msm_pkg::CTRL_ECM] ?
          (rd_en && s_axi_araddr == msm_pkg::OFF_TIMH) : rtc_tick;
        default: cap_evt = 1'b0;
      endcase
    end
  end

  // Read data mux
  always_comb begin
    rd_val = 32'h0000_0000;
    case (s_axi_araddr)
      msm_pkg::OFF_CTRL: rd_val[msm_pkg::CTRL_W-1:0] = r_reg.ctrl;
      msm_pkg::OFF_PRSC: rd_val[3:0] = r_reg.ps;
      msm_pkg::OFF_TIMH: rd_val[7:0] = r_reg.cnt[15:8];
      msm_pkg::OFF_TIML: rd_val[7:0] = r_reg.cnt[7:0];
      msm_pkg::OFF_ZCAP: rd_val[7:0] = r_reg.cap[15:8];
      msm_pkg::OFF_ZPRV: rd_val[7:0] = r_reg.cap[7:0];
      msm_pkg::OFF_COMM: rd_val[7:0] = r_reg.comm;
      msm_pkg::OFF_DEMAG: rd_val[7:0] = r_reg.demag;
      msm_pkg::OFF_STAT: rd_val[msm_pkg::STAT_W-1:0] = r_reg.stat;
      msm_pkg::OFF_HALL: rd_val[5:0] = {r_reg.hall_tog, sensor_input_pins};
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // Bus slave next state; write address and data taken in either order
  always_comb begin
    a_next = a_reg;
    if (s_axi_awvalid && s_axi_awready) begin
      a_next.aw_got = 1'b1;
      a_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      a_next.w_got = 1'b1;
      a_next.wdata = s_axi_wdata;
      a_next.wstrb0 = s_axi_wstrb[0];
    end
    if (wr_en) begin
      a_next.aw_got = 1'b0;
      a_next.w_got = 1'b0;
      a_next.bvalid = 1'b1;
      a_next.bresp = ((a_reg.awaddr[1:0] == 2'h0) && (a_reg.awaddr <= msm_pkg::OFF_LAST)) ?
        msm_pkg::RESP_OKAY : msm_pkg::RESP_SLVERR;
    end
    if (a_reg.bvalid && s_axi_bready) begin
      a_next.bvalid = 1'b0;
    end
    if (rd_en) begin
      a_next.rvalid = 1'b1;
      a_next.rdata = rd_val;
      a_next.rresp = rd_ok ? msm_pkg::RESP_OKAY : msm_pkg::RESP_SLVERR;
    end else if (a_reg.rvalid && s_axi_rready) begin
      a_next.rvalid = 1'b0;
    end
  end

  // Timer next state; hardware updates follow software writes so sets win
  always_comb begin
    r_next = r_reg;
    r_next.hall_prev = sensor_input_pins;
    if (wr_act) begin
      case (a_reg.awaddr)
        msm_pkg::OFF_CTRL: r_next.ctrl = a_reg.wdata[msm_pkg::CTRL_W-1:0];
        msm_pkg::OFF_PRSC: if (mode == msm_pkg::MODE_CFG) r_next.ps = a_reg.wdata[3:0];
        msm_pkg::OFF_TIMH: if (mode == msm_pkg::MODE_CFG) r_next.cnt[15:8] = a_reg.wdata[7:0];
        msm_pkg::OFF_TIML: if (mode == msm_pkg::MODE_CFG) r_next.cnt[7:0] = a_reg.wdata[7:0];
        msm_pkg::OFF_ZCAP: r_next.cap[15:8] = a_reg.wdata[7:0];
        msm_pkg::OFF_ZPRV: r_next.cap[7:0] = a_reg.wdata[7:0];
        msm_pkg::OFF_COMM: r_next.comm = a_reg.wdata[7:0];
        msm_pkg::OFF_DEMAG: r_next.demag = a_reg.wdata[7:0];
        msm_pkg::OFF_STAT: begin
          if (mode == msm_pkg::MODE_SW) begin
            if (a_reg.wdata[msm_pkg::ST_MINUS] && r_reg.ps != msm_pkg::PS_MIN) r_next.ps = r_reg.ps - 4'h1;
            else if (a_reg.wdata[msm_pkg::ST_PLUS] && r_reg.ps != msm_pkg::PS_MAX) r_next.ps = r_reg.ps + 4'h1;
          end else begin
            r_next.stat = r_reg.stat & ~a_reg.wdata[msm_pkg::STAT_W-1:0];
          end
        end
        default: r_next = r_next;
      endcase
    end
    if (running && src_evt) begin
      r_next.div = tick ? 15'h0000 : r_reg.div + 15'h0001;
    end
    case (mode)
      msm_pkg::MODE_HOLD: begin
        r_next.cnt = 16'h0000;
        r_next.div = 15'h0000;
      end
      msm_pkg::MODE_SW, msm_pkg::MODE_AUTO: begin
        if (tick) begin
          if (r_reg.ctrl[msm_pkg::CTRL_COUNT_DIRECTION_BIT]) begin
            r_next.cnt[15:8] = r_reg.cnt[15:8] - 8'h01;
          end else if (mode == msm_pkg::MODE_AUTO && r_reg.cnt[15:8] == msm_pkg::TIMH_MAX &&
                       r_reg.ps != msm_pkg::PS_MAX) begin
            r_next.ps = r_reg.ps + 4'h1;
            r_next.cnt[15:8] = r_reg.cnt[15:8] >> 1;
            r_next.stat[msm_pkg::ST_PLUS] = 1'b1;
          end else if (r_reg.cnt[15:8] != msm_pkg::TIMH_MAX) begin
            r_next.cnt[15:8] = r_reg.cnt[15:8] + 8'h01;
          end
        end
      end
      msm_pkg::MODE_SPEED: begin
        if (cap_evt && !r_reg.lock) begin
          r_next.cap = r_reg.cnt;
          r_next.cnt = 16'h0000;
          r_next.div = 15'h0000;
          r_next.stat[msm_pkg::ST_CAPT] = 1'b1;
          if (r_reg.cnt < msm_pkg::CNT_LOW_LIMIT && r_reg.ps != msm_pkg::PS_MIN) begin
            r_next.ps = r_reg.ps - 4'h1;
            r_next.stat[msm_pkg::ST_MINUS] = 1'b1;
          end
        end else if (tick) begin
          if (r_reg.cnt == msm_pkg::CNT_MAX) begin
            if (r_reg.ps != msm_pkg::PS_MAX) begin
              r_next.ps = r_reg.ps + 4'h1;
              r_next.cnt = r_reg.cnt >> 1;
              r_next.stat[msm_pkg::ST_PLUS] = 1'b1;
            end
          end else begin
            r_next.cnt = r_reg.cnt + 16'h0001;
          end
        end
        if (!encoder && r_reg.cnt > {r_reg.demag, msm_pkg::CMP_LOW_BYTE}) begin
          r_next.stat[msm_pkg::ST_SPDERR] = 1'b1;
        end
        if (hall_toggled && r_reg.ctrl[msm_pkg::CTRL_TES_HI:msm_pkg::CTRL_TES_LO] == msm_pkg::TES_HALL) begin
          r_next.hall_tog = sensor_input_pins ^ r_reg.hall_prev;
          r_next.stat[msm_pkg::ST_HALL] = 1'b1;
        end
      end
      default: r_next = r_next;
    endcase
    if (rd_en && s_axi_araddr == msm_pkg::OFF_ZPRV) begin
      r_next.lock = 1'b0;
    end else if (rd_en && s_axi_araddr == msm_pkg::OFF_ZCAP && mode == msm_pkg::MODE_SPEED) begin
      r_next.lock = 1'b1;
    end
  end

  // State registers; clock enable low freezes everything except a reset, which still clears them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_reg <= msm_pkg::REGS_RESET;
      a_reg <= msm_pkg::AXI_RESET;
    end else if (ce) begin
      r_reg <= r_next;
      a_reg <= a_next;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_cfg_prsc_write;
    ce && wr_act && a_reg.awaddr == msm_pkg::OFF_PRSC && mode == msm_pkg::MODE_CFG
      |=> r_reg.ps == $past(a_reg.wdata[3:0]);
  endproperty
  a_cfg_prsc_write: assert property (p_cfg_prsc_write) else $error("config write to prescaler lost");

  property p_ro_timh;
    ce && wr_act && a_reg.awaddr == msm_pkg::OFF_TIMH && mode == msm_pkg::MODE_SPEED && !cap_evt
      |=> r_reg.cnt == $past(r_reg.cnt) || r_reg.cnt == $past(r_reg.cnt) + 16'h0001 ||
        r_reg.cnt == $past(r_reg.cnt) >> 1;
  endproperty
  a_ro_timh: assert property (p_ro_timh) else $error("read-only timer was written");

  property p_sw_plus;
    ce && wr_act && a_reg.awaddr == msm_pkg::OFF_STAT && mode == msm_pkg::MODE_SW &&
      !a_reg.wdata[msm_pkg::ST_MINUS] && a_reg.wdata[msm_pkg::ST_PLUS] && r_reg.ps != msm_pkg::PS_MAX
      |=> r_reg.ps == $past(r_reg.ps) + 4'h1;
  endproperty
  a_sw_plus: assert property (p_sw_plus) else $error("switched plus write did not step");

  property p_capture;
    ce && mode == msm_pkg::MODE_SPEED && cap_evt && !r_reg.lock
      |=> r_reg.cap == $past(r_reg.cnt) && r_reg.cnt == 16'h0000 && capture_flag;
  endproperty
  a_capture: assert property (p_capture) else $error("capture did not copy and clear");

  property p_lock_hold;
    ce && r_reg.lock && !wr_act ##1 ce && r_reg.lock && !wr_act |-> $stable(r_reg.cap);
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("capture changed while locked");

  property p_overflow;
    ce && mode == msm_pkg::MODE_SPEED && tick && !cap_evt && r_reg.cnt == msm_pkg::CNT_MAX &&
      r_reg.ps != msm_pkg::PS_MAX
      |=> r_reg.cnt == 16'h7FFF && prescaler_plus_flag;
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow did not rescale");

  property p_max_hold;
    ce && mode == msm_pkg::MODE_SPEED && !cap_evt && r_reg.cnt == msm_pkg::CNT_MAX &&
      r_reg.ps == msm_pkg::PS_MAX && !wr_act
      |=> r_reg.cnt == msm_pkg::CNT_MAX && r_reg.ps == msm_pkg::PS_MAX;
  endproperty
  a_max_hold: assert property (p_max_hold) else $error("counter left maximum at top prescale");

  property p_speed_err;
    ce && mode == msm_pkg::MODE_SPEED && !encoder && r_reg.cnt > {r_reg.demag, msm_pkg::CMP_LOW_BYTE}
      |=> speed_error_flag [*2];
  endproperty
  a_speed_err: assert property (p_speed_err) else $error("speed error not raised");

  property p_hall;
    ce && mode == msm_pkg::MODE_SPEED && hall_toggled &&
      r_reg.ctrl[msm_pkg::CTRL_TES_HI:msm_pkg::CTRL_TES_LO] == msm_pkg::TES_HALL
      |=> hall_event_flag && r_reg.hall_tog == $past(sensor_input_pins ^ r_reg.hall_prev);
  endproperty
  a_hall: assert property (p_hall) else $error("hall toggle not recorded");
endmodule : msm_timer
